// file: hw/sscr_regs.svh
// Operation
// RL1 - Marking line keeps receiver stopped
// RL2 - Spacing transition while stopped starts cycle
// RL3 - Start detection ignored during selecting cycle
// RL4 - Marking stop element ends cycle, re-arms
// RL5 - Stay idle until next start element
// RL6 - Capture element level, hold until boundary
// RL7 - Marking sets collected bit, spacing clears
// RL8 - Keep collected bits until character complete
// RL9 - Clear previous output; unselected become spacing
// RL10 - Clear strictly before load
// RL11 - Output cycle loads new character
// RL12 - One output bit per code level
// RL13 - Output holds until next character
// RL14 - Marking opens normally closed path
// RL15 - Transmitter frames with start, stop elements
// RL16 - Frame is 7.42 or 11.00 units; unit timing uses the 7.42 frame only
// RL17 - Rate selectable: 60, 75, 100 wpm
// RL18 - Sample at configurable offset, nominally center
// RL19 - One-cycle pulse when output loads
`ifndef SSCR_REGS_SVH
`define SSCR_REGS_SVH

// ***************************************
// Timing
// ***************************************
`define SSCR_CLK_HZ            64'd200000000
`define SSCR_CLK_PERIOD_NS     5
`define SSCR_SEC_PER_MIN       64'd60
`define SSCR_CHARS_PER_WORD    64'd6
// Frame lengths in hundredths of a unit interval: 7.42 and 11.00
`define SSCR_FRAME5_UNITS_X100 64'd742
`define SSCR_FRAME8_UNITS_X100 64'd1100
`define SSCR_UNIT_CYC(wpm) \
   ((`SSCR_CLK_HZ * `SSCR_SEC_PER_MIN * 64'd100) / \
    (64'(wpm) * `SSCR_CHARS_PER_WORD * `SSCR_FRAME5_UNITS_X100))

// ***************************************
// Frame layout
// ***************************************
`define SSCR_LEVELS            5
`define SSCR_LAST_LEVEL        3'h4
`define SSCR_OFS_W             4
`define SSCR_OFS_SHIFT         4
`define SSCR_OFS_NOMINAL       4'h8
`define SSCR_LINE_MARK         1'h1

`endif

// file: hw/sscr_pkg.sv
package sscr_pkg;

   typedef enum logic [1:0] {
      SSCR_WPM_60  = 2'h0,
      SSCR_WPM_75  = 2'h1,
      SSCR_WPM_100 = 2'h2
   } sscr_speed_e;

   typedef enum logic [5:0] {
      ST_STOP  = 6'h01,
      ST_START = 6'h02,
      ST_CODE  = 6'h04,
      ST_CLEAR = 6'h08,
      ST_LOAD  = 6'h10,
      ST_TAIL  = 6'h20
   } sscr_state_e;

   typedef logic [31:0] sscr_cyc_t;

endpackage

// file: hw/sscr_if.sv
`timescale 1ns/10ps
`default_nettype none

interface sscr_if;
   import sscr_pkg::*;
   logic      run;
   logic      line;
   sscr_cyc_t unit_cyc;
   sscr_cyc_t ofs_cyc;
   logic      smp;
   logic      lvl;

   modport ctl (output run, line, unit_cyc, ofs_cyc, input smp, lvl);
   modport elem (input run, line, unit_cyc, ofs_cyc, output smp, lvl);
endinterface

`default_nettype wire

// file: hw/sscr_sampler.sv
`timescale 1ns/10ps
`default_nettype none

module sscr_sampler (
   // Clock and reset
   input  wire logic core_clk_i,
   input  wire logic nrst_i,
   // Element timing
   sscr_if.elem      tim
);
   import sscr_pkg::*;

   sscr_cyc_t cnt;
   sscr_cyc_t next_cnt;
   logic      smp;
   logic      next_smp;
   logic      lvl;
   logic      next_lvl;
   logic      hit;

   // Counter restarts at the start transition, so every sample point
   // sits at a fixed offset from it
   always_comb begin
      hit = tim.run && (cnt == tim.ofs_cyc);
      next_smp = hit; // RL18
      next_lvl = hit ? tim.line : lvl; // RL6
      if (!tim.run || cnt == tim.unit_cyc - 32'h1) begin
         next_cnt = 32'h0;
      end else begin
         next_cnt = cnt + 32'h1;
      end
   end

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cnt <= 32'h0;
         smp <= 1'h0;
         lvl <= 1'h1;
      end else begin
         cnt <= next_cnt;
         smp <= next_smp;
         lvl <= next_lvl;
      end
   end

   assign tim.smp = smp;
   assign tim.lvl = lvl;

   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   lvl_hold_a: assert property ($changed(lvl) |-> smp) // RL6
      else $error("sampled level changed outside a sample point");
   smp_at_ofs_a: assert property (smp |-> $past(cnt) == $past(tim.ofs_cyc)) // RL18
      else $error("sample strobe not at configured offset");

endmodule

`default_nettype wire

// file: hw/sscr_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sscr_regs.svh"

module sscr_top #(
   parameter logic [31:0] UNIT_CYC_60  = 32'(`SSCR_UNIT_CYC(60)), // RL16
   parameter logic [31:0] UNIT_CYC_75  = 32'(`SSCR_UNIT_CYC(75)),
   parameter logic [31:0] UNIT_CYC_100 = 32'(`SSCR_UNIT_CYC(100))
) (
   // Clock and reset
   input  wire logic                    core_clk_i,
   input  wire logic                    nrst_i,
   // Line and configuration
   input  wire logic                    line_i,
   input  wire sscr_pkg::sscr_speed_e   speed_sel_i,
   input  wire logic [`SSCR_OFS_W-1:0]  sample_ofs_i,
   // Parallel character output
   output var  logic [`SSCR_LEVELS-1:0] code_o,
   output var  logic [`SSCR_LEVELS-1:0] contact_nc_o,
   output var  logic                    new_char_o,
   output var  logic                    busy_o
);
   import sscr_pkg::*;

   // ***************************************
   // Line synchroniser
   // ***************************************
   logic line_m;
   logic line_s;
   logic line_q;
   // Configuration pins are static, but still pass two flops first
   sscr_speed_e            speed_m;
   sscr_speed_e            speed_s;
   logic [`SSCR_OFS_W-1:0] ofs_m;
   logic [`SSCR_OFS_W-1:0] ofs_s;

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         line_m  <= `SSCR_LINE_MARK;
         line_s  <= `SSCR_LINE_MARK;
         line_q  <= `SSCR_LINE_MARK;
         speed_m <= SSCR_WPM_60;
         speed_s <= SSCR_WPM_60;
         ofs_m   <= `SSCR_OFS_NOMINAL;
         ofs_s   <= `SSCR_OFS_NOMINAL;
      end else begin
         line_m  <= line_i;
         line_s  <= line_m;
         line_q  <= line_s;
         speed_m <= speed_sel_i;
         speed_s <= speed_m;
         ofs_m   <= sample_ofs_i;
         ofs_s   <= ofs_m;
      end
   end

   // ***************************************
   // Element timing
   // ***************************************
   sscr_if    u_tim ();
   sscr_cyc_t unit_cyc;

   always_comb begin
      case (speed_s) // RL17
         SSCR_WPM_60: begin
            unit_cyc = UNIT_CYC_60;
         end
         SSCR_WPM_75: begin
            unit_cyc = UNIT_CYC_75;
         end
         SSCR_WPM_100: begin
            unit_cyc = UNIT_CYC_100;
         end
         default: begin
            unit_cyc = UNIT_CYC_60;
         end
      endcase
   end

   assign u_tim.line     = line_s;
   assign u_tim.unit_cyc = unit_cyc;
   // Offset in sixteenths of a unit; truncation moves it slightly early
   assign u_tim.ofs_cyc  = 32'((unit_cyc >> `SSCR_OFS_SHIFT)
                                * {28'h0, ofs_s}); // RL18

   sscr_sampler u_smp (
      .core_clk_i (core_clk_i),
      .nrst_i     (nrst_i),
      .tim        (u_tim.elem)
   );

   // ***************************************
   // Selecting and output cycles
   // ***************************************
   function automatic logic level_hit(input logic [2:0] idx,
                                      input int unsigned lev);
      level_hit = (idx == 3'(lev));
   endfunction

   sscr_state_e             state;
   sscr_state_e             next_state;
   logic [2:0]              elem;
   logic [2:0]              next_elem;
   logic [`SSCR_LEVELS-1:0] collect;
   logic [`SSCR_LEVELS-1:0] next_collect;
   logic [`SSCR_LEVELS-1:0] next_code;
   logic                    next_new;
   logic                    smp;
   logic                    lvl;
   logic                    fall;

   assign smp  = u_tim.smp;
   assign lvl  = u_tim.lvl;
   // Only a real mark-to-space transition counts as a start element
   assign fall = line_q & ~line_s; // RL5

   always_comb begin
      next_state = state;
      next_elem  = elem;
      next_code  = code_o;
      next_new   = 1'h0;
      case (state)
         ST_STOP: begin
            if (fall) begin // RL1 RL2
               next_state = ST_START;
            end
         end
         ST_START: begin
            // Start rechecked at its sample point so glitches are dropped
            if (smp) begin // RL3
               next_elem  = 3'h0;
               next_state = (lvl == `SSCR_LINE_MARK) ? ST_STOP : ST_CODE;
            end
         end
         ST_CODE: begin
            if (smp) begin
               if (elem == `SSCR_LAST_LEVEL) begin
                  next_state = ST_CLEAR;
               end else begin
                  next_elem = elem + 3'h1;
               end
            end
         end
         ST_CLEAR: begin
            next_code  = '0; // RL9 RL10
            next_state = ST_LOAD;
         end
         ST_LOAD: begin
            next_code  = collect; // RL10 RL11
            next_new   = 1'h1; // RL19
            next_state = ST_TAIL;
         end
         ST_TAIL: begin
            // A spacing stop keeps waiting for the next stop sample
            if (smp && lvl == `SSCR_LINE_MARK) begin // RL4
               next_state = ST_STOP;
            end
         end
         default: begin
            next_state = ST_STOP;
         end
      endcase
   end

   genvar g;
   generate
      for (g = 0; g < `SSCR_LEVELS; g++) begin : g_lev
         // Bit g stays held until overwritten by its own level
         assign next_collect[g] =
            (state == ST_CODE && smp && level_hit(elem, g)) ?
            lvl : collect[g]; // RL7 RL8 RL12
      end
   endgenerate

   assign u_tim.run = (state != ST_STOP);

   always_ff @(posedge core_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         state        <= ST_STOP;
         elem         <= 3'h0;
         collect      <= '0;
         code_o       <= '0;
         contact_nc_o <= '1;
         new_char_o   <= 1'h0;
         busy_o       <= 1'h0;
      end else begin
         state        <= next_state;
         elem         <= next_elem;
         collect      <= next_collect;
         code_o       <= next_code; // RL13
         contact_nc_o <= ~next_code; // RL14
         new_char_o   <= next_new;
         busy_o       <= (next_state != ST_STOP);
      end
   end

   // ***************************************
   // Checks
   // ***************************************
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!nrst_i);

   stop_hold_a: assert property ((state == ST_STOP && !fall) |=> state == ST_STOP) // RL1
      else $error("left stop state without a start element");
   start_detect_a: assert property ((state == ST_STOP && fall) |=> state == ST_START) // RL2
      else $error("start element not taken");
   no_restart_a: assert property (
      (state inside {ST_CODE, ST_CLEAR, ST_LOAD, ST_TAIL})
      |=> state != ST_START) // RL3
      else $error("start detection active inside a cycle");
   stop_end_a: assert property ((state == ST_TAIL && smp && lvl) |=> state == ST_STOP) // RL4
      else $error("stop element did not end the cycle");
   collect_bit_a: assert property (
      (state == ST_CODE && smp) |=> collect[$past(elem)] == $past(lvl)) // RL7
      else $error("collected bit differs from sampled level");
   clear_load_a: assert property (
      (state == ST_CLEAR) |=> (code_o == '0 && !new_char_o)
      ##1 (new_char_o && code_o == $past(collect))) // RL10
      else $error("output not cleared then loaded");
   out_hold_a: assert property (
      $changed(code_o) |-> ($past(state) == ST_CLEAR || new_char_o)) // RL13
      else $error("output changed outside an output cycle");
   contact_a: assert property (contact_nc_o == ~code_o) // RL14
      else $error("contact path not inverse of stored level");
   new_pulse_a: assert property (new_char_o |=> !new_char_o) // RL19
      else $error("new character pulse longer than one cycle");

   char_done_c: cover property (new_char_o);
   false_start_c: cover property (state == ST_START ##1 state == ST_STOP);
   back_to_back_c: cover property (state == ST_TAIL ##1 state == ST_STOP
                                   ##[1:1000] state == ST_START);
   spacing_stop_c: cover property (state == ST_TAIL && smp && !lvl);

endmodule

`default_nettype wire

// file: dv/sscr_tx_model.sv
`timescale 1ns/10ps
`default_nettype none

module sscr_tx_model (
   // Clock
   input  wire logic core_clk_i,
   // Serial line, 1 = marking
   output var  logic line_o
);
   // Idle line is marking so the receiver sits in its stop state
   initial line_o = 1'h1;

   task automatic hold(input logic lvl, input int unsigned n);
      line_o <= lvl;
      repeat (n) @(posedge core_clk_i);
   endtask

   // Unit length picks the rate; stop stretched to a 7.42 unit frame
   task automatic send(input logic [4:0] ch, input int unsigned u);
      hold(1'h0, u);
      for (int k = 0; k < 5; k++) begin
         hold(ch[k], u);
      end
      hold(1'h1, (u * 142) / 100);
   endtask

   // Spacing too short to survive the start sample
   task automatic glitch(input int unsigned n);
      hold(1'h0, n);
      hold(1'h1, 1);
   endtask
endmodule

`default_nettype wire

// file: dv/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`include "sscr_regs.svh"

module tb_top;
   import sscr_pkg::*;
   localparam int unsigned U60  = 64;
   localparam int unsigned U75  = 48;
   localparam int unsigned U100 = 32;

   logic                    core_clk;
   logic                    nrst;
   logic                    line;
   sscr_speed_e             speed_sel;
   logic [`SSCR_OFS_W-1:0]  sample_ofs;
   logic [`SSCR_LEVELS-1:0] code;
   logic [`SSCR_LEVELS-1:0] contact_nc;
   logic [`SSCR_LEVELS-1:0] prev_code;
   logic                    new_char;
   logic                    busy;
   int                      mismatches;
   int                      checks;
   int                      nchar;
   int unsigned             u;

   sscr_top #(
      .UNIT_CYC_60  (32'(U60)),
      .UNIT_CYC_75  (32'(U75)),
      .UNIT_CYC_100 (32'(U100))
   ) i_dut (
      .core_clk_i   (core_clk),
      .nrst_i       (nrst),
      .line_i       (line),
      .speed_sel_i  (speed_sel),
      .sample_ofs_i (sample_ofs),
      .code_o       (code),
      .contact_nc_o (contact_nc),
      .new_char_o   (new_char),
      .busy_o       (busy)
   );

   sscr_tx_model i_tx (
      .core_clk_i (core_clk),
      .line_o     (line)
   );

   initial core_clk = 1'h0;
   always #2.5 core_clk = ~core_clk;

   // ***************************************
   // Checking
   // ***************************************
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t: seen %0h expected %0h", $time, seen, exp);
      end
   endtask

   task automatic final_report();
      $display("checks %0d mismatches %0d", checks, mismatches);
      if (mismatches == 0 && checks > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // Output may only change by a clear to zero or by a load with the pulse
   always @(posedge core_clk) begin
      if (nrst === 1'h1) begin
         if (new_char === 1'h1) begin
            nchar++;
            check(32'(prev_code), 32'h0);
            check(32'(contact_nc), {27'h0, ~code});
         end else if (code !== prev_code) begin
            check(32'(code), 32'h0);
         end
      end
      prev_code <= code;
   end

   // ***************************************
   // Scenarios
   // ***************************************
   task automatic rx(input logic [4:0] ch);
      int n0;
      n0 = nchar;
      i_tx.send(ch, u);
      check(32'(nchar - n0), 32'h1);
      check(32'(code), 32'(ch));
      check(32'(contact_nc), {27'h0, ~ch});
      check(32'(busy), 32'h0);
   endtask

   task automatic t_idle();
      int hi;
      hi = 0;
      repeat (3 * U60) begin
         @(posedge core_clk);
         if (busy !== 1'h0) hi++;
      end
      check(32'(hi), 32'h0);
      check(32'(nchar), 32'h0);
   endtask

   // Characters back to back at every speed code, 3 behaves as 60
   task automatic t_chars();
      logic [4:0] pat [5];
      pat = '{5'h15, 5'h0A, 5'h1F, 5'h00, 5'h01};
      for (int s = 0; s < 4; s++) begin
         speed_sel <= sscr_speed_e'(s);
         u = (s == 1) ? U75 : (s == 2) ? U100 : U60;
         foreach (pat[i]) rx(pat[i]);
      end
   endtask

   task automatic t_false_start();
      int n0;
      n0 = nchar;
      i_tx.glitch(2);
      repeat (2 * u) @(posedge core_clk);
      check(32'(nchar - n0), 32'h0);
      check(32'(busy), 32'h0);
      check(32'(code), 32'h01);
   endtask

   // Early and late sample points still read an exact frame
   task automatic t_offset();
      sample_ofs <= 4'h2;
      rx(5'h13);
      sample_ofs <= 4'hE;
      rx(5'h0C);
      sample_ofs <= `SSCR_OFS_NOMINAL;
   endtask

   task automatic t_hold();
      int n0;
      n0 = nchar;
      repeat (4 * u) @(posedge core_clk);
      check(32'(code), 32'h0C);
      check(32'(nchar - n0), 32'h0);
   endtask

   // Spacing where the stop belongs keeps the cycle open until marking
   task automatic t_open_stop();
      int n0;
      n0 = nchar;
      i_tx.hold(1'h0, u);
      for (int k = 0; k < 5; k++) begin
         i_tx.hold(k[0], u);
      end
      i_tx.hold(1'h0, 2 * u);
      check(32'(busy), 32'h1);
      check(32'(nchar - n0), 32'h1);
      check(32'(code), 32'h0A);
      i_tx.hold(1'h1, 2 * u);
      check(32'(busy), 32'h0);
      check(32'(nchar - n0), 32'h1);
   endtask

   // ***************************************
   // Main sequence
   // ***************************************
   initial begin
      mismatches = 0;
      checks = 0;
      nchar = 0;
      u = U60;
      nrst = 1'h0;
      speed_sel = SSCR_WPM_60;
      sample_ofs = `SSCR_OFS_NOMINAL;
      prev_code = '0;
      repeat (3) @(posedge core_clk);
      check(32'(code), 32'h0);
      check(32'(contact_nc), 32'h1F);
      check(32'({new_char, busy}), 32'h0);
      nrst <= 1'h1;
      repeat (4) @(posedge core_clk);
      t_idle();
      t_chars();
      t_false_start();
      t_offset();
      t_hold();
      t_open_stop();
      final_report();
   end

   // Run needs about 10k cycles; this is well beyond
   initial begin
      #400000;
      mismatches++;
      final_report();
   end
endmodule

`default_nettype wire
